// ===== rtl/wdog_cfg_pkg.sv
// Constants and carrier types for the watchdog configuration decoder.
package wdog_cfg_pkg;
    // Mode field codes.
    localparam logic [1:0] MODE_OFF    = 2'h0;
    localparam logic [1:0] MODE_SOFT   = 2'h1;
    localparam logic [1:0] MODE_AWAKE  = 2'h2;
    localparam logic [1:0] MODE_ALWAYS = 2'h3;
    // Window codes.
    localparam logic [2:0] WIN_FREE    = 3'h7;
    localparam logic [2:0] WIN_FULL    = 3'h6;
    // Period codes and divider exponents.
    localparam logic [4:0] PER_SOFT    = 5'h1f;
    localparam logic [4:0] PER_SOFT_LD = 5'h0b;
    localparam logic [4:0] PER_MAX     = 5'h12;
    localparam logic [4:0] EXP_BASE    = 5'h05;
    localparam logic [4:0] EXP_EIGHTHS = 5'h03;
    // Clock source codes.
    localparam logic [2:0] CLK_LFINT   = 3'h0;
    localparam logic [2:0] CLK_MFINT   = 3'h1;
    localparam logic [2:0] CLK_SECONDARY_OSC    = 3'h2;
    localparam logic [2:0] CLK_SOFT    = 3'h7;
    // Oscillator lane indices within the reference clock vector.
    localparam int OSC_LF = 0;
    localparam int OSC_MF = 1;
    localparam int OSC_SO = 2;
    localparam int CNT_W  = 24;

    typedef struct packed {
        logic [2:0] clock_source_cfg;
        logic [2:0] window_select_cfg;
        logic [1:0] wdog_mode_cfg;
        logic [4:0] period_select_cfg;
    } cfg_pins_t;

    typedef struct packed {
        logic       soft_enable_bit;
        logic       sleeping;
        logic       clear;
        logic       key_ok;
        logic       period_wr;
        logic [4:0] period_wdata;
        logic       window_wr;
        logic [2:0] window_wdata;
        logic [1:0] clk_sel;
    } sw_ctrl_t;

    typedef struct packed {
        logic       running;
        logic       window_open;
        logic       keyed_access_req;
        logic       window_writable;
        logic       period_writable;
        logic [4:0] runtime_period_setting;
        logic [2:0] window_setting;
    } wdog_status_t;

    typedef enum logic [1:0] {
        ST_LOAD   = 2'b01,
        ST_ACTIVE = 2'b10
    } phase_t;
endpackage

// ===== rtl/watchdog_config_decode.sv
// Watchdog that decodes its power-on configuration fields and times out on a windowed period.
// Functional notes
// [RL1] Window codes 111 and 110 give a fully open window, and only 111 lets software change it without a key.
// [RL2] Window codes 101 down to 000 close the window for 2/8 to 7/8 of the period, forbid window writes and need the key.
// [RL3] Mode 11 runs the watchdog always, even in sleep, and ignores the software enable bit.
// [RL4] Mode 10 runs only while awake, holds the count during sleep, and ignores the software enable bit.
// [RL5] Mode 01 runs or stops with the software enable bit.
// [RL6] Mode 00 keeps the watchdog off whatever the software enable bit says.
// [RL7] The period field loads the run-time period, code n up to 10010 divides by 2^(5+n), and 10011 to 11110 divide by 32.
// [RL8] Period code 11111 loads 01011 and leaves the period writable, every other code locks it.
// [RL9] When not off, the clock field picks the low, mid or secondary oscillator, or software picks on 111.
// [RL10] A reset is raised when the count reaches the period uncleared or when a clear with key_ok comes while the window is closed.
`timescale 1ns/100ps
module watchdog_config_decode
    import wdog_cfg_pkg::*;
(
    // Clock and reset.
    input  wire logic                      clk,
    input  wire logic                      nrst,
    // Configuration straps and oscillator pins.
    input  wire wdog_cfg_pkg::cfg_pins_t   cfg_pins,
    input  wire logic [2:0]                osc_in,
    // Software control.
    input  wire wdog_cfg_pkg::sw_ctrl_t    sw,
    // Status and reset request.
    output logic                           wdog_reset,
    output wdog_cfg_pkg::wdog_status_t     status
);
    import wdog_cfg_pkg::*;

    typedef struct packed {
        phase_t           phase;
        cfg_pins_t        cfg_s1;
        cfg_pins_t        cfg_s2;
        cfg_pins_t        cfg;
        logic [2:0]       osc_s1;
        logic [2:0]       osc_s2;
        logic [2:0]       osc_s3;
        logic [CNT_W-1:0] count;
        logic [1:0]       fill;
        logic             rst_pulse;
        wdog_status_t     st;
    } state_t;

    localparam state_t STATE_RESET = '{phase: ST_LOAD, default: '0};

    logic   [1:0] rst_sync;
    logic         rst_n;
    state_t       cur;
    state_t       next_cur;

    // Period exponent from a period code; out-of-range codes fall back to 1:32.
    function automatic logic [4:0] period_exp(input logic [4:0] code);
        period_exp = (code <= PER_MAX) ? EXP_BASE + code : EXP_BASE; // [RL7]
    endfunction

    // Closed part of the window in eighths of the period.
    function automatic logic [2:0] closed_eighths(input logic [2:0] code);
        closed_eighths = (code >= WIN_FULL) ? 3'h0 : 3'h7 - code; // [RL1] [RL2]
    endfunction

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    always_comb begin
        logic             enabled;
        logic             ref_tick;
        logic [2:0]       osc_rise;
        logic [4:0]       exp_now;
        logic [CNT_W-1:0] last;
        logic [CNT_W-1:0] upper;
        logic             closed;
        logic             clear_ok;
        enabled  = 1'b0;
        ref_tick = 1'b0;
        osc_rise = 3'h0;
        exp_now  = 5'h0;
        last     = '0;
        upper    = '0;
        closed   = 1'b0;
        clear_ok = 1'b0;
        next_cur = cur;
        next_cur.cfg_s1    = cfg_pins;
        next_cur.cfg_s2    = cur.cfg_s1;
        next_cur.osc_s1    = osc_in;
        next_cur.osc_s2    = cur.osc_s1;
        next_cur.osc_s3    = cur.osc_s2;
        next_cur.rst_pulse = 1'b0;
        unique case (cur.phase)
            ST_LOAD: begin
                // Straps settle through the synchroniser before the single capture, so the
                // capture waits until both stages hold pin values rather than reset zeros.
                next_cur.fill = {cur.fill[0], 1'b1};
                if (cur.fill[1]) begin
                    next_cur.cfg   = cur.cfg_s2;
                    next_cur.phase = ST_ACTIVE;
                    next_cur.count = '0;
                    next_cur.st.window_setting  = cur.cfg_s2.window_select_cfg;
                    next_cur.st.window_writable = (cur.cfg_s2.window_select_cfg == WIN_FREE); // [RL1]
                    next_cur.st.keyed_access_req = (cur.cfg_s2.window_select_cfg != WIN_FREE); // [RL2]
                    if (cur.cfg_s2.period_select_cfg == PER_SOFT) begin
                        next_cur.st.runtime_period_setting = PER_SOFT_LD; // [RL8]
                        next_cur.st.period_writable        = 1'b1; // [RL8]
                    end else begin
                        next_cur.st.runtime_period_setting = cur.cfg_s2.period_select_cfg; // [RL7]
                        next_cur.st.period_writable        = 1'b0; // [RL8]
                    end
                end
            end
            ST_ACTIVE: begin
                unique case (cur.cfg.wdog_mode_cfg)
                    MODE_ALWAYS: enabled = 1'b1; // [RL3]
                    MODE_AWAKE:  enabled = !sw.sleeping; // [RL4]
                    MODE_SOFT:   enabled = sw.soft_enable_bit; // [RL5]
                    MODE_OFF:    enabled = 1'b0; // [RL6]
                endcase
                osc_rise = cur.osc_s2 & ~cur.osc_s3;
                case (cur.cfg.clock_source_cfg)
                    CLK_LFINT: ref_tick = osc_rise[OSC_LF]; // [RL9]
                    CLK_MFINT: ref_tick = osc_rise[OSC_MF]; // [RL9]
                    CLK_SECONDARY_OSC:  ref_tick = osc_rise[OSC_SO]; // [RL9]
                    CLK_SOFT:  ref_tick = (sw.clk_sel <= 2'(OSC_SO)) && osc_rise[sw.clk_sel]; // [RL9]
                    default:   ref_tick = 1'b0;
                endcase
                // Software writes land only where the straps leave the field open.
                if (sw.window_wr && cur.st.window_writable) begin
                    next_cur.st.window_setting = sw.window_wdata; // [RL1]
                end
                if (sw.period_wr && cur.st.period_writable) begin
                    next_cur.st.runtime_period_setting = sw.period_wdata; // [RL8]
                end
                exp_now  = period_exp(cur.st.runtime_period_setting);
                last     = CNT_W'((CNT_W+1)'(1) << exp_now) - CNT_W'(1);
                upper    = cur.count >> (exp_now - EXP_EIGHTHS);
                closed   = upper < CNT_W'(closed_eighths(cur.st.window_setting)); // [RL2]
                clear_ok = !cur.st.keyed_access_req || sw.key_ok; // [RL2]
                next_cur.st.running     = enabled;
                next_cur.st.window_open = enabled && !closed;
                if (!enabled) begin
                    // Sleep in the awake-only mode holds the count rather than losing it.
                    if (cur.cfg.wdog_mode_cfg != MODE_AWAKE) begin
                        next_cur.count = '0; // [RL6]
                    end
                end else if (sw.clear && clear_ok) begin
                    next_cur.count     = '0;
                    next_cur.rst_pulse = closed; // [RL10]
                end else if (ref_tick) begin
                    if (cur.count >= last) begin
                        next_cur.count     = '0;
                        next_cur.rst_pulse = 1'b1; // [RL10]
                    end else begin
                        next_cur.count = cur.count + CNT_W'(1);
                    end
                end
            end
            default: begin
                next_cur = STATE_RESET;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= STATE_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    assign wdog_reset = cur.rst_pulse;
    assign status     = cur.st;
endmodule // watchdog_config_decode

// ===== verif/wdog_chk_asserts.sv
// Concurrent checks on the ports of the watchdog configuration decoder.
`timescale 1ns/100ps
module wdog_chk
    import wdog_cfg_pkg::*;
(
    // Clock and reset.
    input wire logic                        clk,
    input wire logic                        nrst,
    // Watched ports.
    input wire wdog_cfg_pkg::cfg_pins_t     cfg_pins,
    input wire logic [2:0]                  osc_in,
    input wire wdog_cfg_pkg::sw_ctrl_t      sw,
    input wire logic                        wdog_reset,
    input wire wdog_cfg_pkg::wdog_status_t  status
);
    logic [3:0] age;
    logic       up;
    // Straps settle a few edges after release, so the decode checks wait for a full count.
    assign up = (age == 4'hf);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) age <= 4'h0;
        else if (!up) age <= age + 4'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_pulse_once: assert property (wdog_reset |=> !wdog_reset)
        else $error("watchdog reset longer than one cycle");
    a_mode_off: assert property (status.running |-> cfg_pins.wdog_mode_cfg != MODE_OFF)
        else $error("running with mode off");
    a_mode_always: assert property (up && cfg_pins.wdog_mode_cfg == MODE_ALWAYS |-> status.running)
        else $error("always mode not running");
    a_mode_awake: assert property ((up && cfg_pins.wdog_mode_cfg == MODE_AWAKE && !sw.sleeping)[*3] |-> status.running)
        else $error("awake mode not running");
    a_mode_soft: assert property ((up && cfg_pins.wdog_mode_cfg == MODE_SOFT && !sw.soft_enable_bit)[*3] |-> !status.running)
        else $error("soft mode runs without enable");
    a_key_need: assert property (up |-> status.keyed_access_req == (cfg_pins.window_select_cfg != WIN_FREE))
        else $error("keyed access flag wrong");
    a_period_lock: assert property (up |-> status.period_writable == (cfg_pins.period_select_cfg == PER_SOFT))
        else $error("period lock wrong");
    a_period_hold: assert property (up && !status.period_writable |=> $stable(status.runtime_period_setting))
        else $error("locked period changed");
    a_clear_closed: assert property (sw.clear && sw.key_ok && status.running && !status.window_open |=> wdog_reset)
        else $error("closed window clear gave no reset");
endmodule // wdog_chk
bind watchdog_config_decode wdog_chk chk (.clk(clk), .nrst(nrst), .cfg_pins(cfg_pins),
    .osc_in(osc_in), .sw(sw), .wdog_reset(wdog_reset), .status(status));

// ===== verif/tb_watchdog_config_decode.sv
// Self-checking bench for the watchdog configuration decoder.
`timescale 1ns/100ps
module tb_watchdog_config_decode;
    import wdog_cfg_pkg::*;
    logic         clk = 1'b0;
    logic         nrst = 1'b0;
    logic         wd_rst;
    logic [2:0]   osc_in = 3'h0;
    cfg_pins_t    cfg_pins = '0;
    sw_ctrl_t     sw = '0;
    wdog_status_t status;
    wdog_status_t exp_q[$];
    int           fail_count = 0;
    int           comparisons = 0;
    int           pulses = 0;
    event         chk;
    always #4 clk = ~clk;
    watchdog_config_decode uut (.clk(clk), .nrst(nrst), .cfg_pins(cfg_pins), .osc_in(osc_in),
        .sw(sw), .wdog_reset(wd_rst), .status(status));
    always @(posedge clk) if (wd_rst === 1'b1) pulses++;
    // The window flag depends on the live count, so it is masked from status compares.
    always @(chk) begin
        wdog_status_t e;
        e = exp_q.pop_front();
        comparisons++;
        if ((status & 13'h17ff) !== e) begin
            fail_count++;
            $display("mismatch status expected %h seen %h", e, status);
        end
    end
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic boot(input cfg_pins_t c);
        nrst = 1'b0;
        cfg_pins = c;
        repeat (16) @(posedge clk);
        #1 nrst = 1'b1;
        repeat (8) @(posedge clk);
        #1 pulses = 0;
    endtask
    task automatic note(input wdog_status_t e);
        exp_q.push_back(e);
        -> chk;
    endtask
    task automatic cnt(input int e);
        comparisons++;
        if (pulses != e) begin
            fail_count++;
            $display("mismatch wdog_reset pulses expected %0d seen %0d", e, pulses);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            repeat (3) @(posedge clk);
            #1 osc_in = 3'h4;
            repeat (3) @(posedge clk);
            #1 osc_in = 3'h0;
        end
        repeat (8) @(posedge clk);
        #1;
    endtask
    task automatic poke(input sw_ctrl_t s);
        sw = s;
        @(posedge clk);
        #1 sw.clear = 1'b0;
        sw.period_wr = 1'b0;
        sw.window_wr = 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    initial begin
        logic [4:0] p;
        void'($urandom(32'h7b92));
        for (int i = 0; i < 8; i++) begin
            p = (i == 7) ? PER_SOFT : (i == 6) ? 5'h13 : 5'($urandom_range(18));
            sw.soft_enable_bit = 1'($urandom_range(1));
            sw.sleeping = i[1] & i[0];
            boot('{CLK_SECONDARY_OSC, i[2:0], i[1:0], p});
            note('{(i % 4 > 1) || (i % 4 == 1 && sw.soft_enable_bit), 1'b0, i != 7, i == 7,
                i == 7, (i == 7) ? PER_SOFT_LD : p, i[2:0]});
        end
        $display("test decode done");
        sw = '0;
        boot('{CLK_SECONDARY_OSC, WIN_FREE, MODE_ALWAYS, 5'h00});
        ticks(31);
        cnt(0);
        ticks(1);
        cnt(1);
        $display("test timeout done");
        boot('{CLK_SECONDARY_OSC, 3'h0, MODE_ALWAYS, 5'h00});
        for (int k = 0; k < 2; k++) begin
            poke('{1'b0, 1'b0, 1'b1, k[0], 1'b1, 5'h05, 1'b1, 3'h3, 2'h0});
            cnt(k);
        end
        note('{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 5'h00, 3'h0});
        $display("test closed window done");
        p = 5'($urandom_range(18));
        boot('{CLK_SECONDARY_OSC, WIN_FREE, MODE_ALWAYS, PER_SOFT});
        poke('{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, p, 1'b1, 3'h3, 2'h0});
        note('{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, p, 3'h3});
        $display("test writable done");
        #20 end_sim();
    end
    initial begin
        #100000;
        fail_count++;
        end_sim();
    end
endmodule // tb_watchdog_config_decode
